// ### include/sdc_map.svh
// Register map, field positions, reset values and cycle counts of the SDRAM controller.
// Included by every design file that decodes registers or pins and by the testbench.
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// Register byte offsets from the peripheral base
`define SDC_OFS_REFCTL 12'h040
`define SDC_OFS_GPIO 12'h044
`define SDC_OFS_CFG0 12'h048
`define SDC_OFS_PINS 12'h04c
`define SDC_OFS_CFG1 12'h050

// Block configuration fields
`define SDC_CFG_BASE_HI 31
`define SDC_CFG_BASE_LO 18
`define SDC_CFG_EN 15
`define SDC_CFG_WP 8
`define SDC_CFG_RST 32'h0000_0000

// Refresh control: count field and its reset value, 16 cycles per count step
`define SDC_RC_W 9
`define SDC_RC_RST 9'h040
`define SDC_REF_FILL 4'hf

// Port register fields: outputs in [4:0], directions in [12:8]
`define SDC_GPO_HI 4
`define SDC_GDIR_HI 12
`define SDC_GDIR_LO 8

// Row and column slices of the internal address
`define SDC_ROW_HI 17
`define SDC_ROW_LO 10
`define SDC_COL_HI 9
`define SDC_COL_LO 2

// Cycle counts of the access and refresh sequences
`define SDC_RCD_CYC 4'h2
`define SDC_CL_CYC 4'h2
`define SDC_SYNC_CYC 4'h2
`define SDC_WR_CYC 4'h2
`define SDC_RP_CYC 4'h2
`define SDC_RFC_CYC 4'h7

`endif

// ### include/sdc_pkg.sv
// Types shared by the SDRAM controller core and its refresh and data units.
// Assumes sdc_map.svh sits on the include path.
package sdc_pkg;

    // Controller sequence states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RCD = 5'h02,
        S_LAT = 5'h04,
        S_PRE = 5'h08,
        S_REF = 5'h10
    } sdc_state_t;

    // Core state: registers, bus phase, synchronisers, sequencer, pins
    typedef struct packed {
        logic [31:0] cfg0;
        logic [31:0] cfg1;
        logic [8:0] rc;
        logic [4:0] gpo;
        logic [4:0] gdir;
        logic ph_v;
        logic ph_w;
        logic [11:0] ph_a;
        logic [31:0] rdata;
        logic [1:0] mode_s;
        logic [4:0] gin_s1;
        logic [4:0] gin_s2;
        sdc_state_t st;
        logic [3:0] cnt;
        logic blk;
        logic we;
        logic [31:0] addr;
        logic [4:0] pin;
        logic [4:0] oe;
        logic [11:0] a;
        logic ack;
        logic miss;
    } sdc_core_t;

    // Refresh counter state
    typedef struct packed {
        logic [12:0] cnt;
        logic req;
    } sdc_ref_t;

    // Data unit state
    typedef struct packed {
        logic [31:0] s1;
        logic [31:0] s2;
        logic [31:0] dout;
        logic oe;
        logic [31:0] rdata;
    } sdc_dat_t;

endpackage

// ### rtl/sdc_refresh.sv
// Refresh interval counter of the SDRAM controller.
// Assumes the core acknowledges a request with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"

module sdc_refresh import sdc_pkg::*; (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [8:0] refresh_count, // Interval in steps of 16 cycles
    input wire logic run, // Low in single-chip mode
    input wire logic ref_ack, // Refresh issued, one-cycle pulse
    output logic ref_req // Refresh due, held until acknowledged
);
    sdc_ref_t q, n;

    // Reload on expiry; a new expiry beats a same-cycle acknowledge
    always_comb begin
        n = q;
        if (!run || q.cnt == 13'h0) begin
            n.cnt = {refresh_count, `SDC_REF_FILL};
        end else begin
            n.cnt = q.cnt - 13'h1;
        end
        n.req = (run && q.cnt == 13'h0) || (q.req && !ref_ack);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign ref_req = q.req;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // The counter sits at zero through reset, so the release edge must not start an attempt
    a_req_on_expiry: assert property (rstn && run && q.cnt == 13'h0 |=> ref_req)
        else $error("refresh request missing at expiry");
    a_req_held: assert property (ref_req && !ref_ack |=> ref_req)
        else $error("refresh request dropped without service");
endmodule
`default_nettype wire

// ### rtl/sdc_data.sv
// Data steering between the internal bus and the external memory data pins.
// Assumes the core pulses wr_go with the write command and rd_go at the sample point.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"

module sdc_data import sdc_pkg::*; (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic wr_go, // Drive write data next cycle
    input wire logic rd_go, // Take synchronised read data
    input wire logic [31:0] wdata, // Write data from the internal bus
    input wire logic [31:0] dq_in, // Memory data pins, input side
    output logic [31:0] dq_out, // Memory data pins, output side
    output logic dq_oe, // Memory data pins driven
    output logic [31:0] rdata // Read data to the internal bus
);
    sdc_dat_t q, n;

    // Pins pass two stages before capture; output drive lines up with the command
    always_comb begin
        n = q;
        n.s1 = dq_in;
        n.s2 = q.s1;
        n.oe = wr_go;
        if (wr_go) begin
            n.dout = wdata;
        end
        if (rd_go) begin
            n.rdata = q.s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign dq_out = q.dout;
    assign dq_oe = q.oe;
    assign rdata = q.rdata;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_write_drive: assert property (wr_go |=> dq_oe && dq_out == $past(wdata))
        else $error("write data not driven with command");
    a_read_take: assert property (rd_go |=> rdata == $past(q.s2))
        else $error("read data not captured");
endmodule
`default_nettype wire

// ### rtl/sdc_ctrl.sv
// SDRAM controller core: AHB-Lite registers, hit logic, command sequencer, pin mux.
// Assumes one AHB-Lite master, memory requests held until mem_ack, and
// single_chip_mode and gpio_in arriving from pins.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"

module sdc_ctrl import sdc_pkg::*; (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB ready in
    output logic hreadyout, // AHB ready out
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic mem_req, // Memory request, held until mem_ack
    input wire logic mem_we, // Memory request is a write
    input wire logic [31:0] mem_addr, // Memory request address
    input wire logic [31:0] mem_wdata, // Memory write data
    output logic [31:0] mem_rdata, // Memory read data
    output logic mem_ack, // Request done, one-cycle pulse
    output logic mem_miss, // Request hit no block or came in port mode, with mem_ack
    input wire logic single_chip_mode, // Mode pin, high for port use
    input wire logic [4:0] gpio_in, // Port pin levels
    output logic row_strobe_n, // Row strobe or port bit 4
    output logic column_strobe_n, // Column strobe or port bit 3
    output logic mem_write_n, // Write line or port bit 2
    output logic [1:0] sel_n, // Block selects or port bits 1:0
    output logic [4:0] pin_oe, // Drive enables of those pins
    output logic [11:0] sd_addr, // Shared row and column address
    input wire logic [31:0] dq_in, // Memory data in
    output logic [31:0] dq_out, // Memory data out
    output logic dq_oe, // Memory data driven
    output logic transfer_in_progress_n // External transfer flag
);
    sdc_core_t q, n;
    logic ref_req;
    logic ref_go;
    logic go;
    logic wr_go;
    logic rd_go;
    logic [4:0] cmd;
    logic [11:0] a_n;
    logic [1:0] hit;
    logic [1:0] blk_cs;
    logic [31:0] cfg [2];

    // Hit logic: each enabled block matches its base, write-protect refuses writes
    assign cfg[0] = q.cfg0;
    assign cfg[1] = q.cfg1;
    for (genvar b = 0; b < 2; b++) begin : g_hit
        assign hit[b] = cfg[b][`SDC_CFG_EN]
            && mem_addr[`SDC_CFG_BASE_HI:`SDC_CFG_BASE_LO]
               == cfg[b][`SDC_CFG_BASE_HI:`SDC_CFG_BASE_LO]
            && !(mem_we && cfg[b][`SDC_CFG_WP]);
    end

    // Select pattern of the block being served; block 0 wins an overlap
    assign blk_cs = q.blk ? 2'b01 : 2'b10;

    // Registers, bus, sequencer and pin mux in one next-state process
    always_comb begin
        n = q;
        n.ack = 1'b0;
        n.miss = 1'b0;
        go = 1'b0;
        ref_go = 1'b0;
        wr_go = 1'b0;
        rd_go = 1'b0;
        cmd = 5'h1f;
        a_n = q.a;
        n.mode_s = {q.mode_s[0], single_chip_mode};
        n.gin_s1 = gpio_in;
        n.gin_s2 = q.gin_s1;

        // Data phase write; narrow writes are dropped
        if (q.ph_v && q.ph_w) begin
            case (q.ph_a)
                `SDC_OFS_CFG0: n.cfg0 = hwdata;
                `SDC_OFS_CFG1: n.cfg1 = hwdata;
                `SDC_OFS_REFCTL: n.rc = hwdata[`SDC_RC_W-1:0];
                `SDC_OFS_GPIO: begin
                    n.gpo = hwdata[`SDC_GPO_HI:0];
                    n.gdir = hwdata[`SDC_GDIR_HI:`SDC_GDIR_LO];
                end
                default: n.rc = n.rc;
            endcase
        end

        // Address phase; read data comes from the updated copy so that a read
        // right behind a write to the same register sees the new value
        n.ph_v = hsel && hready && htrans[1];
        n.ph_w = hwrite && hsize == 3'h2;
        n.ph_a = haddr[11:0];
        if (n.ph_v && !hwrite) begin
            case (haddr[11:0])
                `SDC_OFS_CFG0: n.rdata = n.cfg0;
                `SDC_OFS_CFG1: n.rdata = n.cfg1;
                `SDC_OFS_REFCTL: n.rdata = {23'h0, n.rc};
                `SDC_OFS_GPIO: n.rdata = {19'h0, n.gdir, 3'h0, n.gpo};
                `SDC_OFS_PINS: n.rdata = {27'h0, q.gin_s2};
                default: n.rdata = 32'h0;
            endcase
        end

        // Sequencer: refresh has priority over a waiting access
        case (q.st)
            S_IDLE: begin
                if (ref_req && !q.mode_s[1]) begin
                    ref_go = 1'b1;
                    cmd = 5'b00100;
                    n.cnt = `SDC_RFC_CYC;
                    n.st = S_REF;
                end else if (mem_req && !q.ack) begin
                    if (hit != 2'b00 && !q.mode_s[1]) begin
                        go = 1'b1;
                        n.blk = !hit[0];
                        n.we = mem_we;
                        n.addr = mem_addr;
                        cmd = {3'b011, hit[0] ? 2'b10 : 2'b01};
                        a_n = {4'h0, mem_addr[`SDC_ROW_HI:`SDC_ROW_LO]};
                        n.cnt = `SDC_RCD_CYC;
                        n.st = S_RCD;
                    end else begin
                        n.ack = 1'b1;
                        n.miss = 1'b1;
                    end
                end
            end
            S_RCD: begin
                cmd = {3'b111, blk_cs};
                if (q.cnt == 4'h1) begin
                    cmd = {2'b10, !q.we, blk_cs};
                    a_n = {4'h0, q.addr[`SDC_COL_HI:`SDC_COL_LO]};
                    wr_go = q.we;
                    n.cnt = q.we ? `SDC_WR_CYC : `SDC_CL_CYC + `SDC_SYNC_CYC + 4'h1;
                    n.st = S_LAT;
                end else begin
                    n.cnt = q.cnt - 4'h1;
                end
            end
            S_LAT: begin
                cmd = {3'b111, blk_cs};
                if (q.cnt == 4'h1) begin
                    rd_go = !q.we;
                    cmd = {3'b010, blk_cs};
                    a_n = 12'h0;
                    n.cnt = `SDC_RP_CYC;
                    n.st = S_PRE;
                end else begin
                    n.cnt = q.cnt - 4'h1;
                end
            end
            S_PRE: begin
                if (q.cnt == 4'h1) begin
                    n.ack = 1'b1;
                    n.st = S_IDLE;
                end else begin
                    n.cnt = q.cnt - 4'h1;
                end
            end
            S_REF: begin
                if (q.cnt == 4'h1) begin
                    n.st = S_IDLE;
                end else begin
                    n.cnt = q.cnt - 4'h1;
                end
            end
            default: n.st = S_IDLE;
        endcase

        // Port mode hands the pins to software; memory use drives them always
        n.pin = q.mode_s[1] ? q.gpo : cmd;
        n.oe = q.mode_s[1] ? q.gdir : 5'h1f;
        n.a = a_n;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
            q.rc <= `SDC_RC_RST;
            q.st <= S_IDLE;
            q.pin <= 5'h1f;
            q.oe <= 5'h1f;
        end else begin
            q <= n;
        end
    end

    // Refresh pacing, stopped while the pins serve as a port
    sdc_refresh u_refresh (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .refresh_count(q.rc),
        .run(!q.mode_s[1]),
        .ref_ack(ref_go),
        .ref_req(ref_req)
    );

    // Data steering between the buses
    sdc_data u_data (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_go(wr_go),
        .rd_go(rd_go),
        .wdata(mem_wdata),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .rdata(mem_rdata)
    );

    // Pin and bus outputs from flops; hreadyout and hresp tied off
    assign row_strobe_n = q.pin[4];
    assign column_strobe_n = q.pin[3];
    assign mem_write_n = q.pin[2];
    assign sel_n = q.pin[1:0];
    assign pin_oe = q.oe;
    assign sd_addr = q.a;
    assign mem_ack = q.ack;
    assign mem_miss = q.miss;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    // No non-memory transfers run through this block
    assign transfer_in_progress_n = 1'b1;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_activate;
        !row_strobe_n && column_strobe_n && mem_write_n;
    endsequence

    sequence s_column;
        row_strobe_n && !column_strobe_n;
    endsequence

    a_ras_activate: assert property (go |=> s_activate)
        else $error("activate lacks row strobe");
    a_cas_column: assert property (q.st == S_RCD && q.cnt == 4'h1 |=> s_column)
        else $error("column command lacks column strobe");
    a_write_line: assert property (q.st == S_RCD && q.cnt == 4'h1 |=> mem_write_n == !$past(q.we))
        else $error("write line does not match direction");
    a_sel_block: assert property (go && hit[0] |=> sel_n == 2'b10)
        else $error("block 0 select wrong");
    a_port_mode: assert property (q.mode_s[1] ##1 q.mode_s[1] |-> row_strobe_n == $past(q.gpo[4]))
        else $error("port bit not on row strobe pin");
    a_cfg_write: assert property (q.ph_v && q.ph_w && q.ph_a == `SDC_OFS_CFG0 |=> q.cfg0 == $past(hwdata))
        else $error("block 0 configuration write lost");
    a_refresh_both: assert property (ref_go |=> sel_n == 2'b00 && !row_strobe_n && !column_strobe_n)
        else $error("refresh not issued to both blocks");
    a_ref_service: assert property (ref_req && q.st == S_IDLE && !q.mode_s[1] |=> q.st == S_REF)
        else $error("idle sequencer ignored refresh");
    a_miss_answer: assert property (mem_req && !q.ack && q.st == S_IDLE && !ref_req && hit == 2'b00 |=> mem_ack && mem_miss)
        else $error("missed request not answered");
    a_addr_mux: assert property (go |=> sd_addr[7:0] == $past(mem_addr[17:10]) ##2 sd_addr[7:0] == $past(q.addr[9:2]))
        else $error("row or column address wrong");
    a_access_walk: assert property (go |=> s_activate ##2 s_column)
        else $error("access sequence out of step");
    a_tip_quiet: assert property (q.st != S_IDLE |-> transfer_in_progress_n)
        else $error("transfer flag during memory access");
    a_ack_bound: assert property (go |-> ##[4:12] mem_ack)
        else $error("access not acknowledged in time");
endmodule
`default_nettype wire

// ### test/sdc_sdram_model.sv
// Behavioural model of the two SDRAM blocks behind the controller pins.
// Assumes commands are sampled on the rising edge of the system clock, CL of two.
`timescale 1ns/1ps
`default_nettype none

module sdc_sdram_model (
    input wire logic clk_sys, // System clock
    input wire logic row_strobe_n, // Row strobe
    input wire logic column_strobe_n, // Column strobe
    input wire logic mem_write_n, // Write line
    input wire logic [1:0] sel_n, // Block selects
    input wire logic [11:0] sd_addr, // Shared address
    input wire logic [31:0] dq_out, // Data from the controller
    input wire logic dq_oe, // Controller drives data
    output logic [31:0] dq_in, // Data to the controller
    output int n_ref, // Refresh commands to both blocks
    output int n_bad, // Illegal command patterns seen
    output logic [11:0] act_row, // Row of the last activate
    output logic [11:0] col, // Column of the last read or write
    output logic [1:0] last_sel // Selects of the last activate
);
    logic [31:0] mem [logic [25:0]];
    logic [31:0] rd_q;
    logic [2:0] rcnt;

    initial begin
        n_ref = 0;
        n_bad = 0;
        rcnt = 3'h0;
        rd_q = 32'h0;
        act_row = 12'h0;
        col = 12'h0;
        last_sel = 2'h3;
    end

    // Command decode; each block keeps its own storage, keyed by its select
    always @(posedge clk_sys) begin
        if (sel_n != 2'h3) begin
            case ({row_strobe_n, column_strobe_n, mem_write_n})
                3'h3: begin
                    act_row <= sd_addr;
                    last_sel <= sel_n;
                    if (sel_n == 2'h0) n_bad <= n_bad + 1;
                end
                3'h4: begin
                    if (dq_oe !== 1'b1) n_bad <= n_bad + 1;
                    mem[{sel_n, act_row, sd_addr}] = dq_out;
                    col <= sd_addr;
                end
                3'h5: begin
                    rd_q <= mem.exists({sel_n, act_row, sd_addr}) ?
                        mem[{sel_n, act_row, sd_addr}] : 32'h5a5a_a5a5;
                    col <= sd_addr;
                end
                3'h1: begin
                    if (sel_n == 2'h0) n_ref <= n_ref + 1;
                    else n_bad <= n_bad + 1;
                end
                default: ;
            endcase
        end
        if (sel_n != 2'h3 && {row_strobe_n, column_strobe_n, mem_write_n} == 3'h5) rcnt <= 3'h1;
        else if (rcnt != 3'h0) rcnt <= (rcnt == 3'h4) ? 3'h0 : rcnt + 3'h1;
    end

    // Read data is valid for three sample edges only; elsewhere the bus shows
    // the inverse so a late or early sample cannot pass by luck
    assign dq_in = (rcnt >= 3'h2) ? rd_q : ~rd_q;

endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the SDRAM controller core with its SDRAM model.
// Assumes one AHB-Lite master at 200 MHz and sdc_map.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"

module testbench;
    localparam logic [31:0] peripheral_base = 32'h4000_0000;
    logic clk_sys = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_addr = 32'h0, mem_wdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, mem_req = 1'b0, mem_we = 1'b0, mem_ack, mem_miss;
    logic [31:0] mem_rdata, dq_in, dq_out;
    logic single_chip_mode = 1'b0, row_strobe_n, column_strobe_n, mem_write_n, dq_oe;
    logic [4:0] gpio_in = 5'h0, pin_oe;
    logic [1:0] sel_n, last_sel, es;
    logic [11:0] sd_addr, act_row, col;
    logic transfer_in_progress_n, ms, tip_low = 1'b0;
    logic [31:0] q, a, d;
    logic [8:0] rc;
    int n_ref, n_bad, lat, r0, cycles = 0, n_errors = 0, comparisons = 0;

    assign hready = hreadyout;
    sdc_ctrl dut (.*);
    sdc_sdram_model mp (.*);

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single-word AHB transfer; read data is taken at the data-phase edge
    task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
        haddr <= peripheral_base + {20'h0, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp, input string n);
        ahb(1'b0, ofs, 32'h0);
        chk(n, q, exp);
        chk("response", hresp, 32'h0);
    endtask

    // Memory request held until acknowledged, then dropped for one cycle
    task automatic mop(input logic we, input logic [31:0] ad, input logic [31:0] wd);
        r0 = n_ref;
        mem_req <= 1'b1;
        mem_we <= we;
        mem_addr <= ad;
        mem_wdata <= wd;
        lat = 0;
        do begin
            @(posedge clk_sys);
            lat++;
            tip_low |= (transfer_in_progress_n !== 1'b1);
        end while (mem_ack !== 1'b1);
        mem_req <= 1'b0;
        q = mem_rdata;
        ms = mem_miss;
        @(posedge clk_sys);
    endtask

    // A refresh that went first may add up to eight cycles
    task automatic lchk(input int e);
        chk("latency", lat, (n_ref != r0 && lat > e && lat <= e + 8) ? lat : e);
    endtask

    task automatic conclude();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cut a hang short; the whole run needs well under 6000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk("idle pins", {row_strobe_n, column_strobe_n, mem_write_n, sel_n}, 5'h1f);
        rd_chk(12'h048, 32'h0, "cfg0 reset");
        rd_chk(12'h050, 32'h0, "cfg1 reset");
        rd_chk(`SDC_OFS_REFCTL, 32'h40, "refresh count reset");
        ahb(1'b1, 12'h048, 32'h0000_8000);
        ahb(1'b1, 12'h050, 32'h0004_8000);
        ahb(1'b1, 12'h0f0, 32'hffff_ffff);
        rd_chk(12'h048, 32'h0000_8000, "cfg0");
        rd_chk(12'h050, 32'h0004_8000, "cfg1");
        rd_chk(12'h0f0, 32'h0, "unmapped");
        $display("test registers done");

        // Same row and column in both blocks, so only the selects keep the data apart
        for (int b = 0; b < 2; b++) begin
            a = {13'h0, b[0], 8'ha5, 8'h3c, 2'h0};
            d = 32'hc0de_0000 | b;
            es = ~(2'h1 << b);
            mop(1'b1, a, d);
            chk("write miss", ms, 1'b0);
            lchk(8);
            chk("row address", act_row[7:0], a[17:10]);
            chk("column address", col[7:0], a[9:2]);
            chk("select", last_sel, es);
            mop(1'b0, a, 32'h0);
            chk("read data", q, d);
            lchk(11);
        end
        mop(1'b0, 32'h0002_94f0, 32'h0);
        chk("block 0 kept", q, 32'hc0de_0000);
        mop(1'b1, 32'h0010_0000, 32'h1);
        chk("no block hit", ms, 1'b1);
        lchk(2);
        ahb(1'b1, 12'h050, 32'h0004_8100);
        mop(1'b1, 32'h0006_94f0, 32'hdead_beef);
        chk("protected write", ms, 1'b1);
        mop(1'b0, 32'h0006_94f0, 32'h0);
        chk("protected data", q, 32'hc0de_0001);
        chk("transfer flag", tip_low, 1'b0);
        $display("test memory done");

        // Both blocks refreshed together, about ten intervals per window
        for (int i = 0; i < 2; i++) begin
            rc = i ? 9'h003 : 9'h001;
            ahb(1'b1, `SDC_OFS_REFCTL, {23'h0, rc});
            r0 = n_ref;
            while (n_ref == r0) @(posedge clk_sys);
            r0 = n_ref;
            repeat (160 * (rc + 1)) @(posedge clk_sys);
            chk("refresh rate", (n_ref - r0 >= 9) && (n_ref - r0 <= 11), 1'b1);
        end
        chk("command faults", n_bad, 0);
        $display("test refresh done");

        // Single-chip mode: pins follow the port register, requests miss
        single_chip_mode <= 1'b1;
        gpio_in <= 5'h0d;
        ahb(1'b1, `SDC_OFS_GPIO, 32'h0000_1b1e);
        repeat (6) @(posedge clk_sys);
        chk("port pins", {row_strobe_n, column_strobe_n, mem_write_n, sel_n}, 5'h1e);
        chk("port enables", pin_oe, 5'h1b);
        rd_chk(`SDC_OFS_PINS, 32'h0000_000d, "port levels");
        mop(1'b1, 32'h0, 32'h2);
        chk("port mode miss", ms, 1'b1);
        single_chip_mode <= 1'b0;
        repeat (20) @(posedge clk_sys);
        mop(1'b0, 32'h0002_94f0, 32'h0);
        chk("memory mode back", q, 32'hc0de_0000);
        chk("memory enables", pin_oe, 5'h1f);
        $display("test port mode done");
        conclude();
    end

endmodule
`default_nettype wire
